// [ssr_consts.svh]
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH

// register byte offsets
`define SSR_OFF_ID 12'h000
`define SSR_OFF_STS 12'h008
`define SSR_OFF_RXC 12'h00c
`define SSR_OFF_TXC 12'h010

// event status field positions
`define SSR_BIT_MACRTO 18
`define SSR_BIT_TXSTOP 17
`define SSR_BIT_RXSTOP 16
`define SSR_BIT_PHY 15
`define SSR_BIT_TXERR 14
`define SSR_BIT_TXUNDER 13
`define SSR_BIT_TXOVER 12
`define SSR_BIT_RXDROP 11
`define SSR_PIN_N 11
`define SSR_STS_W 19
`define SSR_STS_W1C_MASK 19'h77fff

// control field positions
`define SSR_BIT_FLUSH 0
`define SSR_BIT_STOP 1
`define SSR_BIT_TXON 2

// reset values
`define SSR_STS_RST 19'h00000
`define SSR_CNT_RST 20'h00000

// identity, arbitrary values
`define SSR_MODEL_ID 16'h5a5a
`define SSR_REVISION 16'h0001

// axi responses
`define SSR_RESP_OKAY 2'h0
`define SSR_RESP_SLVERR 2'h2

// timing
`define SSR_WDOG_NS 8000000
`define SSR_CLK_NS 8
`define SSR_CNT_W 20

`endif

// [ssr_pkg.sv]
package ssr_pkg;

   typedef enum logic [1:0] {
      WD_IDLE,
      WD_WAIT,
      WD_DONE
   } ssr_wdog_t;

   typedef logic [11:0] ssr_addr_t;

endpackage

// [ssr_regs.sv]
`timescale 1ns/100ps
`include "ssr_consts.svh"
module ssr_regs #(
   parameter logic [15:0] MODEL_ID = `SSR_MODEL_ID,
   parameter logic [15:0] REVISION = `SSR_REVISION,
   parameter int unsigned WDOG_CYCLES = `SSR_WDOG_NS / `SSR_CLK_NS
) (
   input logic clk,
   input logic rst_n,
   input logic [11:0] s_axi_awaddr,
   input logic s_axi_awvalid,
   output logic s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0] s_axi_wstrb,
   input logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic [11:0] s_axi_araddr,
   input logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input logic s_axi_rready,
   input logic mac_reset_req,
   input logic phy_rx_clk_present,
   input logic phy_tx_clk_present,
   output logic mac_reset_hold,
   input logic tx_halted,
   input logic tx_datapath_empty,
   input logic rx_halt_pulse,
   input logic phy_event_level_level_internal,
   input logic phy_event_level_level_external,
   input logic phy_select_external,
   input logic tx_error_pulse,
   input logic tx_fifo_underrun_pulse,
   input logic tx_fifo_overrun_pulse,
   input logic rx_frame_drop_pulse,
   input logic [10:0] pin_event_level,
   output logic [10:0] pin_wake_clear,
   output logic rx_fifo_flush,
   output logic tx_fifo_flush,
   output logic tx_enable,
   output logic tx_stop_req
);

   // write channel state
   logic aw_held_q;
   logic w_held_q;
   ssr_pkg::ssr_addr_t aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;

   // read channel state
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   // register state
   logic [`SSR_STS_W-1:0] sts_q;
   logic [`SSR_STS_W-1:0] sts_d;
   logic [10:0] pin_wake_clear_q;
   logic rx_flush_q;
   logic tx_flush_q;
   logic stop_q;
   logic stop_d;
   logic tx_on_q;
   logic tx_on_d;

   // watchdog state
   ssr_pkg::ssr_wdog_t wd_q;
   ssr_pkg::ssr_wdog_t wd_d;
   logic [`SSR_CNT_W-1:0] cnt_q;
   logic mac_reset_hold_q;

   // axi write handshake
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire wr_fire = aw_held_q && w_held_q;

   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready = !w_held_q && !bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   wire [11:0] wr_word = {aw_addr_q[11:2], 2'h0};
   wire wr_id = wr_fire && (wr_word == `SSR_OFF_ID);
   wire wr_sts = wr_fire && (wr_word == `SSR_OFF_STS);
   wire wr_rxc = wr_fire && (wr_word == `SSR_OFF_RXC);
   wire wr_txc = wr_fire && (wr_word == `SSR_OFF_TXC);
   wire wr_hit = wr_id || wr_sts || wr_rxc || wr_txc;

   // byte lanes gate every bit, so a narrow write touches nothing else
   wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                        {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   wire [31:0] wbits = w_data_q & wmask;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= 12'h000;
      end else if (aw_take) begin
         aw_held_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         w_held_q <= 1'b0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
      end else if (w_take) begin
         w_held_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid_q <= 1'b0;
         bresp_q <= `SSR_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? `SSR_RESP_OKAY : `SSR_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // axi read path
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire [11:0] rd_word = {s_axi_araddr[11:2], 2'h0};
   wire rd_id = rd_word == `SSR_OFF_ID;
   wire rd_sts = rd_word == `SSR_OFF_STS;
   wire rd_rxc = rd_word == `SSR_OFF_RXC;
   wire rd_txc = rd_word == `SSR_OFF_TXC;
   wire rd_hit = rd_id || rd_sts || rd_rxc || rd_txc;

   wire phy_level = phy_select_external ? phy_event_level_level_external
                                        : phy_event_level_level_internal;

   wire [31:0] val_id = {MODEL_ID, REVISION};
   wire [31:0] val_sts = {13'h0000, sts_q[18:16], phy_level, sts_q[14:0]};
   wire [31:0] val_rxc = {31'h00000000, rx_flush_q};
   wire [31:0] val_txc = {29'h00000000, tx_on_q, stop_q, tx_flush_q};

   wire [31:0] rd_data = rd_id ? val_id :
                         rd_sts ? val_sts :
                         rd_rxc ? val_rxc :
                         rd_txc ? val_txc : 32'h00000000;

   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `SSR_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_data;
         rresp_q <= rd_hit ? `SSR_RESP_OKAY : `SSR_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // mac reset watchdog
   wire clocks_ok = phy_rx_clk_present && phy_tx_clk_present;
   wire cnt_last = cnt_q == `SSR_CNT_W'(WDOG_CYCLES - 1);
   wire wd_expire = (wd_q == ssr_pkg::WD_WAIT) && mac_reset_req
                    && !clocks_ok && cnt_last;

   always_comb begin
      wd_d = wd_q;
      case (wd_q)
         ssr_pkg::WD_IDLE: begin
            if (mac_reset_req) begin
               wd_d = ssr_pkg::WD_WAIT;
            end
         end
         ssr_pkg::WD_WAIT: begin
            if (!mac_reset_req) begin
               wd_d = ssr_pkg::WD_IDLE;
            end else if (clocks_ok || wd_expire) begin
               wd_d = ssr_pkg::WD_DONE;
            end
         end
         ssr_pkg::WD_DONE: begin
            if (!mac_reset_req) begin
               wd_d = ssr_pkg::WD_IDLE;
            end
         end
         default: begin
            wd_d = ssr_pkg::WD_IDLE;
         end
      endcase
   end

   // hold drops on the expiry edge itself; no clock from the phy is needed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wd_q <= ssr_pkg::WD_IDLE;
         cnt_q <= `SSR_CNT_RST;
         mac_reset_hold_q <= 1'b0;
      end else begin
         wd_q <= wd_d;
         cnt_q <= (wd_d == ssr_pkg::WD_WAIT) ? cnt_q + 1'b1 : `SSR_CNT_RST;
         mac_reset_hold_q <= wd_d == ssr_pkg::WD_WAIT;
      end
   end

   assign mac_reset_hold = mac_reset_hold_q;

   // graceful stop completes only once the datapath has drained
   wire stop_done = stop_q && tx_halted && tx_datapath_empty;
   wire stop_wr = wr_txc && wbits[`SSR_BIT_STOP] && !stop_q;

   // event status
   wire [`SSR_STS_W-1:0] sts_set = {
      wd_expire,
      stop_done,
      rx_halt_pulse,
      1'b0,
      tx_error_pulse,
      tx_fifo_underrun_pulse,
      tx_fifo_overrun_pulse,
      rx_frame_drop_pulse,
      pin_event_level
   };
   wire [`SSR_STS_W-1:0] sts_clr = wr_sts ? (wbits[18:0] & `SSR_STS_W1C_MASK)
                                          : `SSR_STS_RST;

   // pin levels re-set their bits every cycle, so they reflect pins after reset
   assign sts_d = (sts_q & ~sts_clr) | sts_set;

   assign stop_d = stop_done ? 1'b0 : (stop_wr ? 1'b1 : stop_q);
   // hardware stop completion outranks a same-cycle enable write
   assign tx_on_d = stop_done ? 1'b0 :
                    (wr_txc && w_strb_q[0]) ? wbits[`SSR_BIT_TXON] : tx_on_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sts_q <= `SSR_STS_RST;
         pin_wake_clear_q <= 11'h000;
      end else begin
         sts_q <= sts_d;
         pin_wake_clear_q <= sts_clr[10:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_flush_q <= 1'b0;
         tx_flush_q <= 1'b0;
         stop_q <= 1'b0;
         tx_on_q <= 1'b0;
      end else begin
         rx_flush_q <= wr_rxc && wbits[`SSR_BIT_FLUSH];
         tx_flush_q <= wr_txc && wbits[`SSR_BIT_FLUSH];
         stop_q <= stop_d;
         tx_on_q <= tx_on_d;
      end
   end

   assign pin_wake_clear = pin_wake_clear_q;
   assign rx_fifo_flush = rx_flush_q;
   assign tx_fifo_flush = tx_flush_q;
   assign tx_enable = tx_on_q;
   assign tx_stop_req = stop_q;

   // checks
   a_id_read: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ar_take && rd_id) |=> (rdata_q == {MODEL_ID, REVISION}) && rvalid_q)
      else $error("identity word wrong");

   a_wdog_expire: assert property (
      @(posedge clk) disable iff (!rst_n)
      wd_expire |=> sts_q[`SSR_BIT_MACRTO] && !mac_reset_hold_q)
      else $error("watchdog expiry not handled");

   a_wdog_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(mac_reset_hold_q) |-> mac_reset_hold_q [*2] or
      (mac_reset_hold_q ##1 !mac_reset_hold_q))
      else $error("reset hold glitch");

   a_stop_flag: assert property (
      @(posedge clk) disable iff (!rst_n)
      (stop_q && tx_halted && tx_datapath_empty)
      |=> sts_q[`SSR_BIT_TXSTOP] && !stop_q)
      else $error("stop completion not flagged");

   a_rx_halt: assert property (
      @(posedge clk) disable iff (!rst_n)
      rx_halt_pulse |=> sts_q[`SSR_BIT_RXSTOP])
      else $error("receiver halt not latched");

   a_phy_mirror: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ar_take && rd_sts) |=> rdata_q[`SSR_BIT_PHY] ==
      $past(phy_select_external ? phy_event_level_level_external : phy_event_level_level_internal))
      else $error("phy level not mirrored");

   a_tx_error: assert property (
      @(posedge clk) disable iff (!rst_n)
      tx_error_pulse |=> sts_q[`SSR_BIT_TXERR])
      else $error("transmit error not latched");

   a_fifo_under: assert property (
      @(posedge clk) disable iff (!rst_n)
      tx_fifo_underrun_pulse |=> sts_q[`SSR_BIT_TXUNDER])
      else $error("underrun not latched");

   a_fifo_over: assert property (
      @(posedge clk) disable iff (!rst_n)
      tx_fifo_overrun_pulse |=> sts_q[`SSR_BIT_TXOVER])
      else $error("overrun not latched");

   a_frame_drop: assert property (
      @(posedge clk) disable iff (!rst_n)
      rx_frame_drop_pulse |=> sts_q[`SSR_BIT_RXDROP])
      else $error("dropped frame not latched");

   a_pin_level: assert property (
      @(posedge clk) disable iff (!rst_n)
      1'b1 |=> (sts_q[10:0] & $past(pin_event_level)) == $past(pin_event_level))
      else $error("pin level not captured");

   a_pin_wake: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wr_sts && (wbits[10:0] != 11'h000)) |=> pin_wake_clear_q == $past(wbits[10:0]))
      else $error("pin wake not cleared");

   a_w1c_clear: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wr_sts && wbits[`SSR_BIT_TXERR] && !tx_error_pulse)
      |=> !sts_q[`SSR_BIT_TXERR])
      else $error("write one did not clear");

   a_w0_keep: assert property (
      @(posedge clk) disable iff (!rst_n)
      (sts_q[`SSR_BIT_RXDROP] && !(wr_sts && wbits[`SSR_BIT_RXDROP]))
      |=> sts_q[`SSR_BIT_RXDROP])
      else $error("flag lost without clear");

   a_rx_flush: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wr_rxc && wbits[`SSR_BIT_FLUSH]) |=> rx_fifo_flush ##1 !rx_fifo_flush)
      else $error("rx flush not one cycle");

   a_tx_on: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wr_txc && w_strb_q[0] && !stop_done) |=> tx_enable == $past(wbits[`SSR_BIT_TXON]))
      else $error("enable write not taken");

   a_on_cleared: assert property (
      @(posedge clk) disable iff (!rst_n)
      $fell(stop_q) |-> !tx_on_q)
      else $error("enable survives stop");

   a_stop_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      (stop_q && !(tx_halted && tx_datapath_empty)) |=> stop_q)
      else $error("stop cleared early");

   a_stop_empty: assert property (
      @(posedge clk) disable iff (!rst_n)
      $fell(stop_q) |-> $past(tx_datapath_empty))
      else $error("stop cleared with data left");

   a_tx_flush: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wr_txc && wbits[`SSR_BIT_FLUSH]) |=> tx_fifo_flush ##1 !tx_fifo_flush)
      else $error("tx flush not one cycle");

   a_sc_zero: assert property (
      @(posedge clk) disable iff (!rst_n)
      (wr_txc && !wbits[`SSR_BIT_STOP] && !stop_q) |=> !stop_q)
      else $error("zero write set stop");

   a_set_wins: assert property (
      @(posedge clk) disable iff (!rst_n)
      (tx_fifo_underrun_pulse && sts_clr[`SSR_BIT_TXUNDER]) |=> sts_q[`SSR_BIT_TXUNDER])
      else $error("clear beat the event");

endmodule

// [sys_status_txrx_control_regs_bench.sv]
`timescale 1ns/100ps
`include "ssr_consts.svh"
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("BAD %s expected %h seen %h", what, exp, got); end end
module sys_status_txrx_control_regs_bench;
   localparam int WD = 16;
   localparam logic [15:0] MID = 16'h3c3c; // arbitrary model code
   localparam logic [15:0] REV = 16'h0002; // arbitrary revision
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, hold, rxf, txf, txen, stopq;
   logic [1:0] bresp, rresp;
   logic mac_req = 1'b0, rxc = 1'b1, txc = 1'b1, halted = 1'b0, empty = 1'b0;
   logic phy_in = 1'b0, phy_ex = 1'b0, phy_sel = 1'b0;
   logic [4:0] ev = 5'h00;
   logic [10:0] pins = 11'h005;
   logic [10:0] wake;
   logic [10:0] wake_acc = 11'h000;
   int n_rxf = 0, n_txf = 0, n_mismatch = 0, num_checks = 0;

   ssr_regs #(.MODEL_ID(MID), .REVISION(REV), .WDOG_CYCLES(WD)) DUT (
      .clk(clk), .rst_n(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .mac_reset_req(mac_req), .phy_rx_clk_present(rxc), .phy_tx_clk_present(txc),
      .mac_reset_hold(hold), .tx_halted(halted), .tx_datapath_empty(empty),
      .rx_halt_pulse(ev[0]), .phy_event_level_level_internal(phy_in), .phy_event_level_level_external(phy_ex),
      .phy_select_external(phy_sel), .tx_error_pulse(ev[1]), .tx_fifo_underrun_pulse(ev[2]),
      .tx_fifo_overrun_pulse(ev[3]), .rx_frame_drop_pulse(ev[4]), .pin_event_level(pins),
      .pin_wake_clear(wake), .rx_fifo_flush(rxf), .tx_fifo_flush(txf), .tx_enable(txen),
      .tx_stop_req(stopq)
   );

   initial begin
      forever #4 clk = ~clk;
   end

   // pulse outputs are short, so they are caught here rather than polled
   always @(posedge clk) begin
      wake_acc <= wake_acc | wake;
      if (rxf === 1'b1) n_rxf++;
      if (txf === 1'b1) n_txf++;
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic timeout();
      n_mismatch++;
      end_of_test();
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // readies are looked at on the falling edge, where nothing is moving
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_hit, w_hit, b_hit;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(negedge clk);
         aw_hit = awvalid & awready;
         w_hit = wvalid & wready;
         b_hit = bvalid;
         r = bresp;
         @(posedge clk);
         if (aw_hit) awvalid <= 1'b0;
         if (w_hit) wvalid <= 1'b0;
         if (b_hit === 1'b1) begin
            bready <= 1'b0;
            // let an edge pass so a next call never re-drives bready in this step
            @(posedge clk);
            return;
         end
      end
      timeout();
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_hit, r_hit;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(negedge clk);
         ar_hit = arvalid & arready;
         r_hit = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ar_hit) arvalid <= 1'b0;
         if (r_hit === 1'b1) begin
            rready <= 1'b0;
            @(posedge clk);
            return;
         end
      end
      timeout();
   endtask

   task automatic wrs(input logic [11:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
   endtask

   task automatic chk_rd(input string what, input logic [11:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      `CHK(what, e, d)
   endtask

   task automatic fire(input logic [4:0] m);
      ev <= m;
      @(posedge clk);
      ev <= 5'h00;
      @(posedge clk);
   endtask

   task automatic t_ident();
      logic [31:0] d;
      logic [1:0] r;
      chk_rd("identity", `SSR_OFF_ID, {MID, REV});
      wr(`SSR_OFF_ID, 32'hffffffff, r);
      chk_rd("identity after write", `SSR_OFF_ID, {MID, REV});
      rd(12'h004, d, r);
      `CHK("unmapped read resp", `SSR_RESP_SLVERR, r)
      `CHK("unmapped read data", 32'h0, d)
      wr(12'h004, 32'h1, r);
      `CHK("unmapped write resp", `SSR_RESP_SLVERR, r)
   endtask

   task automatic t_pins();
      chk_rd("pins after reset", `SSR_OFF_STS, 32'h005);
      wrs(`SSR_OFF_STS, 32'h7ff);
      chk_rd("pins still high", `SSR_OFF_STS, 32'h005);
      pins <= 11'h000;
      @(negedge clk);
      wake_acc = 11'h000;
      @(posedge clk);
      wrs(`SSR_OFF_STS, 32'h001);
      chk_rd("pin bit cleared", `SSR_OFF_STS, 32'h004);
      `CHK("pin wake clear", 11'h001, wake_acc)
      wrs(`SSR_OFF_STS, 32'h004);
      chk_rd("pins all clear", `SSR_OFF_STS, 32'h0);
   endtask

   task automatic t_pulses();
      int pos[5] = '{16, 14, 13, 12, 11};
      for (int k = 0; k < 5; k++) begin
         fire(5'(1 << k));
         wrs(`SSR_OFF_STS, 32'h0);
         chk_rd("event flag", `SSR_OFF_STS, 32'h1 << pos[k]);
         wrs(`SSR_OFF_STS, 32'h1 << pos[k]);
         chk_rd("event flag cleared", `SSR_OFF_STS, 32'h0);
      end
      // event lands on the very edge that applies the clear
      fork
         wrs(`SSR_OFF_STS, 32'h4000);
         begin
            @(posedge clk);
            ev <= 5'h02;
            @(posedge clk);
            ev <= 5'h00;
         end
      join
      chk_rd("set beats clear", `SSR_OFF_STS, 32'h4000);
      wrs(`SSR_OFF_STS, 32'h4000);
   endtask

   task automatic t_phy();
      phy_in <= 1'b1;
      @(posedge clk);
      chk_rd("phy internal", `SSR_OFF_STS, 32'h8000);
      wrs(`SSR_OFF_STS, 32'h8000);
      chk_rd("phy not clearable", `SSR_OFF_STS, 32'h8000);
      phy_sel <= 1'b1;
      @(posedge clk);
      chk_rd("phy external low", `SSR_OFF_STS, 32'h0);
      phy_ex <= 1'b1;
      @(posedge clk);
      chk_rd("phy external high", `SSR_OFF_STS, 32'h8000);
      phy_ex <= 1'b0;
      phy_in <= 1'b0;
      phy_sel <= 1'b0;
      @(posedge clk);
   endtask

   task automatic t_flush();
      int c = n_rxf;
      int t = n_txf;
      wrs(`SSR_OFF_RXC, 32'h1);
      cyc(2);
      `CHK("rx flush pulses", c + 1, n_rxf)
      chk_rd("rx cfg self clear", `SSR_OFF_RXC, 32'h0);
      wrs(`SSR_OFF_RXC, 32'h0);
      cyc(2);
      `CHK("rx flush on zero", c + 1, n_rxf)
      wrs(`SSR_OFF_TXC, 32'h1);
      cyc(2);
      `CHK("tx flush pulses", t + 1, n_txf)
      chk_rd("tx cfg self clear", `SSR_OFF_TXC, 32'h0);
   endtask

   task automatic t_stop();
      int n = 0;
      wrs(`SSR_OFF_TXC, 32'h4);
      `CHK("tx enable", 1'b1, txen)
      chk_rd("tx cfg enable", `SSR_OFF_TXC, 32'h4);
      wrs(`SSR_OFF_TXC, 32'h6);
      `CHK("stop request", 1'b1, stopq)
      wrs(`SSR_OFF_TXC, 32'h4);
      chk_rd("stop write ignored", `SSR_OFF_TXC, 32'h6);
      halted <= 1'b1;
      cyc(4);
      `CHK("stop held with data", 1'b1, stopq)
      chk_rd("no stop flag yet", `SSR_OFF_STS, 32'h0);
      empty <= 1'b1;
      while (stopq !== 1'b0) begin
         if (n == 10) timeout();
         n++;
         @(negedge clk);
      end
      @(posedge clk);
      `CHK("enable after stop", 1'b0, txen)
      chk_rd("tx cfg after stop", `SSR_OFF_TXC, 32'h0);
      chk_rd("stop flag", `SSR_OFF_STS, 32'h20000);
      wrs(`SSR_OFF_STS, 32'h20000);
      halted <= 1'b0;
      empty <= 1'b0;
   endtask

   task automatic t_wdog();
      int n_hold = 0;
      mac_req <= 1'b1;
      cyc(5);
      `CHK("hold with clocks", 1'b0, hold)
      chk_rd("no timeout flag", `SSR_OFF_STS, 32'h0);
      mac_req <= 1'b0;
      rxc <= 1'b0;
      txc <= 1'b0;
      cyc(2);
      mac_req <= 1'b1;
      repeat (WD + 10) begin
         @(negedge clk);
         if (hold === 1'b1) n_hold++;
      end
      @(posedge clk);
      `CHK("hold length", 1'b1, n_hold >= WD - 1 && n_hold <= WD + 1)
      `CHK("hold released", 1'b0, hold)
      chk_rd("timeout flag", `SSR_OFF_STS, 32'h40000);
      mac_req <= 1'b0;
      rxc <= 1'b1;
      txc <= 1'b1;
      wrs(`SSR_OFF_STS, 32'h40000);
      chk_rd("timeout flag cleared", `SSR_OFF_STS, 32'h0);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      timeout();
   end

   initial begin
      cyc(10);
      rst_n <= 1'b1;
      cyc(2);
      t_ident();
      t_pins();
      t_pulses();
      t_phy();
      t_flush();
      t_stop();
      t_wdog();
      end_of_test();
   end
endmodule
